// ==== core/vpfc_ctrl.sv ====
// Pressure tuning, loop selection with fallback, and target cutoffs
//
// What this block does
// - Twelve fixed pressure presets plus expert choice.
// - Preset B loads gains 0.5, 0.3, 35.
// - Presets C..M follow the fixed faster table.
// - Writing any pressure gain selects expert preset.
// - Hold integral inside dead zone, 0 to 2%.
// - Clamp integrator at upper limit, 0..100%.
// - Clamp integrator at lower limit, -100..0%.
// - Read-only state shows travel or pressure control.
// - Loop selection offers four choices.
// - Auto recovery returns to travel when sensor heals.
// - Manual recovery holds pressure until reselection.
// - Fallback ignores travel sensor alert enable.
// - Range fault or gross deviation triggers fallback.
// - Above travel high cutoff force 123.0%.
// - Below travel low cutoff force -23%.
// - Above pressure open cutoff force 123.0%.
// - Below pressure closed cutoff force -23%.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module vpfc_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Loop inputs
   input wire logic signed [15:0] setpoint,
   input wire logic signed [15:0] pressure_error,
   input wire logic signed [15:0] integrator_raw,
   input wire logic travel_range_fault,
   input wire logic gross_deviation,
   // Loop outputs
   output vpfc_pkg::vpfc_gains_s active_gains,
   output logic signed [15:0] travel_target,
   output logic signed [15:0] pressure_target,
   output logic integral_hold,
   output logic signed [15:0] integrator_clamped,
   output logic active_loop_state,
   output logic fallback_active
);
   function automatic vpfc_pkg::vpfc_val_t sat(
      input vpfc_pkg::vpfc_val_t v,
      input vpfc_pkg::vpfc_val_t lo,
      input vpfc_pkg::vpfc_val_t hi
   );
      sat = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   function automatic vpfc_pkg::vpfc_val_t cutoff(
      input vpfc_pkg::vpfc_val_t sp,
      input vpfc_pkg::vpfc_val_t hi,
      input vpfc_pkg::vpfc_val_t lo
   );
      if (hi != vpfc_pkg::CUT_OFF_HI && sp > hi) begin
         cutoff = vpfc_pkg::CUT_FORCE_HI;
      end else if (lo != vpfc_pkg::CUT_OFF_LO && sp < lo) begin
         cutoff = vpfc_pkg::CUT_FORCE_LO;
      end else begin
         cutoff = sp;
      end
   endfunction

   logic [3:0] preset_reg;
   logic [3:0] preset_next;
   vpfc_pkg::vpfc_sel_e sel_reg;
   vpfc_pkg::vpfc_gains_s gains_reg;
   vpfc_pkg::vpfc_gains_s rom_q;
   logic load_pend_reg;
   vpfc_pkg::vpfc_val_t dead_zone_reg;
   vpfc_pkg::vpfc_val_t upper_reg;
   vpfc_pkg::vpfc_val_t lower_reg;
   vpfc_pkg::vpfc_val_t travel_hi_reg;
   vpfc_pkg::vpfc_val_t travel_lo_reg;
   vpfc_pkg::vpfc_val_t press_open_reg;
   vpfc_pkg::vpfc_val_t press_closed_reg;
   vpfc_pkg::vpfc_val_t range_top_reg;
   vpfc_pkg::vpfc_val_t range_bottom_reg;
   vpfc_pkg::vpfc_loop_e loop_reg;
   vpfc_pkg::vpfc_loop_e loop_next;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic signed [15:0] travel_target_reg;
   logic signed [15:0] pressure_target_reg;
   logic integral_hold_reg;
   logic signed [15:0] integ_clamped_reg;
   logic pressure_ctl_reg;
   logic fallback_reg;

   // Bus decode: one wait state, commit at the edge where pready is high
   wire commit = psel && penable && pready_reg;
   wire wr = commit && pwrite;
   wire vpfc_pkg::vpfc_val_t wval = pwdata[15:0];
   wire wr_ctrl = wr && paddr == vpfc_pkg::OFS_CTRL;
   wire wr_prop = wr && paddr == vpfc_pkg::OFS_PROP;
   wire wr_integ = wr && paddr == vpfc_pkg::OFS_INTEG;
   wire wr_minor_loop = wr && paddr == vpfc_pkg::OFS_MINOR_LOOP;
   wire wr_gain = wr_prop || wr_integ || wr_minor_loop;
   wire [3:0] wpreset = pwdata[vpfc_pkg::CTRL_PRESET_LSB +: 4];
   wire [1:0] wsel = pwdata[vpfc_pkg::CTRL_SEL_LSB +: 2];
   wire wpreset_ok = wpreset <= vpfc_pkg::PRESET_EXPERT;
   wire mapped = paddr[1:0] == 2'b00 && paddr <= vpfc_pkg::OFS_STATUS;
   wire sensor_bad = travel_range_fault || gross_deviation;
   wire vpfc_pkg::vpfc_val_t abs_err =
      pressure_error[15] ? -pressure_error : pressure_error;

   // Illegal preset codes are ignored; the field keeps its value
   assign preset_next = wr_gain ? vpfc_pkg::PRESET_EXPERT :
                        (wr_ctrl && wpreset_ok) ? wpreset : preset_reg;

   // Status word
   wire [31:0] status_word = {30'h0,
      loop_reg == vpfc_pkg::LOOP_FALLBACK,
      loop_reg != vpfc_pkg::LOOP_TRAVEL};

   // Read selection
   wire [15:0] rd_val =
      paddr == vpfc_pkg::OFS_PROP ? gains_reg.prop :
      paddr == vpfc_pkg::OFS_INTEG ? gains_reg.integ :
      paddr == vpfc_pkg::OFS_MINOR_LOOP ? gains_reg.minor_loop :
      paddr == vpfc_pkg::OFS_DEAD_ZONE ? dead_zone_reg :
      paddr == vpfc_pkg::OFS_UPPER_CLAMP ? upper_reg :
      paddr == vpfc_pkg::OFS_LOWER_CLAMP ? lower_reg :
      paddr == vpfc_pkg::OFS_TRAVEL_HI ? travel_hi_reg :
      paddr == vpfc_pkg::OFS_TRAVEL_LO ? travel_lo_reg :
      paddr == vpfc_pkg::OFS_PRESS_OPEN ? press_open_reg :
      paddr == vpfc_pkg::OFS_PRESS_CLOSED ? press_closed_reg :
      paddr == vpfc_pkg::OFS_RANGE_TOP ? range_top_reg :
      paddr == vpfc_pkg::OFS_RANGE_BOTTOM ? range_bottom_reg : 16'h0000;
   wire [31:0] rd_word =
      paddr == vpfc_pkg::OFS_CTRL ? {26'h0, sel_reg, preset_reg} :
      paddr == vpfc_pkg::OFS_STATUS ? status_word : {16'h0000, rd_val};

   // Preset table lookup; address follows the written preset code
   vpfc_gain_rom u_rom (
      .sys_clk(sys_clk),
      .rst(rst),
      .addr(wr_ctrl ? wpreset : preset_reg),
      .q(rom_q)
   );

   // Loop selection and fallback
   always_comb begin
      unique case (sel_reg)
         vpfc_pkg::SEL_TRAVEL: loop_next = vpfc_pkg::LOOP_TRAVEL;
         vpfc_pkg::SEL_PRESSURE: loop_next = vpfc_pkg::LOOP_PRESSURE;
         vpfc_pkg::SEL_FB_AUTO: loop_next = sensor_bad ?
            vpfc_pkg::LOOP_FALLBACK : vpfc_pkg::LOOP_TRAVEL;
         vpfc_pkg::SEL_FB_MANUAL: loop_next =
            (sensor_bad || loop_reg == vpfc_pkg::LOOP_FALLBACK) ?
            vpfc_pkg::LOOP_FALLBACK : vpfc_pkg::LOOP_TRAVEL;
      endcase
   end

   // Bus handshake and read data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
         pslverr_reg <= psel && penable && !pready_reg && !mapped;
         prdata_reg <= (psel && penable && !pready_reg && !pwrite)
                       ? rd_word : 32'h0000_0000;
      end
   end

   // Tuning registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         preset_reg <= vpfc_pkg::PRESET_C;
         sel_reg <= vpfc_pkg::SEL_TRAVEL;
         gains_reg <= vpfc_pkg::RST_GAINS;
         load_pend_reg <= 1'b0;
      end else begin
         preset_reg <= preset_next;
         if (wr_ctrl) begin
            sel_reg <= vpfc_pkg::vpfc_sel_e'(wsel);
         end
         load_pend_reg <= wr_ctrl && wpreset < vpfc_pkg::PRESET_EXPERT;
         if (load_pend_reg) begin
            gains_reg <= rom_q;
         end
         if (wr_prop) begin
            gains_reg.prop <= pwdata[15:0];
         end
         if (wr_integ) begin
            gains_reg.integ <= pwdata[15:0];
         end
         if (wr_minor_loop) begin
            gains_reg.minor_loop <= pwdata[15:0];
         end
      end
   end

   // Limits and cutoffs saturated to their legal spans; range stored as written
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dead_zone_reg <= vpfc_pkg::VAL_ZERO;
         upper_reg <= vpfc_pkg::CLAMP_MAX;
         lower_reg <= vpfc_pkg::CLAMP_MIN;
         travel_hi_reg <= vpfc_pkg::CUT_OFF_HI;
         travel_lo_reg <= vpfc_pkg::CUT_OFF_LO;
         press_open_reg <= vpfc_pkg::CUT_OFF_HI;
         press_closed_reg <= vpfc_pkg::CUT_OFF_LO;
         range_top_reg <= vpfc_pkg::RST_RANGE_TOP;
         range_bottom_reg <= vpfc_pkg::RST_RANGE_BOTTOM;
      end else if (wr) begin
         unique case (paddr)
            vpfc_pkg::OFS_DEAD_ZONE: dead_zone_reg <=
               sat(wval, vpfc_pkg::VAL_ZERO, vpfc_pkg::DEAD_ZONE_MAX);
            vpfc_pkg::OFS_UPPER_CLAMP: upper_reg <=
               sat(wval, vpfc_pkg::VAL_ZERO, vpfc_pkg::CLAMP_MAX);
            vpfc_pkg::OFS_LOWER_CLAMP: lower_reg <=
               sat(wval, vpfc_pkg::CLAMP_MIN, vpfc_pkg::VAL_ZERO);
            vpfc_pkg::OFS_TRAVEL_HI: travel_hi_reg <=
               sat(wval, vpfc_pkg::CUT_OFF_LO, vpfc_pkg::CUT_OFF_HI);
            vpfc_pkg::OFS_TRAVEL_LO: travel_lo_reg <=
               sat(wval, vpfc_pkg::CUT_OFF_LO, vpfc_pkg::CUT_OFF_HI);
            vpfc_pkg::OFS_PRESS_OPEN: press_open_reg <=
               sat(wval, vpfc_pkg::CUT_OFF_LO, vpfc_pkg::CUT_OFF_HI);
            vpfc_pkg::OFS_PRESS_CLOSED: press_closed_reg <=
               sat(wval, vpfc_pkg::CUT_OFF_LO, vpfc_pkg::CUT_OFF_HI);
            vpfc_pkg::OFS_RANGE_TOP: range_top_reg <= wval;
            vpfc_pkg::OFS_RANGE_BOTTOM: range_bottom_reg <= wval;
            default: ;
         endcase
      end
   end

   // Loop datapath
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         loop_reg <= vpfc_pkg::LOOP_TRAVEL;
         travel_target_reg <= vpfc_pkg::VAL_ZERO;
         pressure_target_reg <= vpfc_pkg::VAL_ZERO;
         integral_hold_reg <= 1'b0;
         integ_clamped_reg <= vpfc_pkg::VAL_ZERO;
         pressure_ctl_reg <= 1'b0;
         fallback_reg <= 1'b0;
      end else begin
         loop_reg <= loop_next;
         pressure_ctl_reg <= loop_next != vpfc_pkg::LOOP_TRAVEL;
         fallback_reg <= loop_next == vpfc_pkg::LOOP_FALLBACK;
         travel_target_reg <=
            cutoff(setpoint, travel_hi_reg, travel_lo_reg);
         pressure_target_reg <=
            cutoff(setpoint, press_open_reg, press_closed_reg);
         integral_hold_reg <= abs_err <= dead_zone_reg;
         integ_clamped_reg <= sat(integrator_raw, lower_reg, upper_reg);
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign active_gains = gains_reg;
   assign travel_target = travel_target_reg;
   assign pressure_target = pressure_target_reg;
   assign integral_hold = integral_hold_reg;
   assign integrator_clamped = integ_clamped_reg;
   assign active_loop_state = pressure_ctl_reg;
   assign fallback_active = fallback_reg;

   a_gain_to_expert: assert property (@(posedge sys_clk) disable iff (rst)
      wr_gain |=> preset_reg == vpfc_pkg::PRESET_EXPERT)
      else $error("gain write did not select expert");
   a_preset_b_load: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_ctrl && wpreset == vpfc_pkg::PRESET_B) |-> ##2
      (gains_reg == vpfc_pkg::vpfc_gains_s'{16'h0005, 16'h0003, 16'h0023}))
      else $error("preset B gains wrong");
   a_preset_m_load: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_ctrl && wpreset == vpfc_pkg::PRESET_M) |-> ##2
      (gains_reg == vpfc_pkg::vpfc_gains_s'{16'h005A, 16'h0001, 16'h000C}))
      else $error("preset M gains wrong");
   a_clamp_span: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 (integ_clamped_reg <= $past(upper_reg)
      && integ_clamped_reg >= $past(lower_reg)))
      else $error("integrator outside clamps");
   a_dead_zone_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (pressure_error == 16'sh0000) |=> integral_hold_reg)
      else $error("integral not held at zero error");
   a_fallback_enter: assert property (@(posedge sys_clk) disable iff (rst)
      (sensor_bad && (sel_reg == vpfc_pkg::SEL_FB_AUTO
      || sel_reg == vpfc_pkg::SEL_FB_MANUAL)) |=> fallback_active)
      else $error("no fallback on sensor fault");
   a_auto_recover: assert property (@(posedge sys_clk) disable iff (rst)
      (!sensor_bad && sel_reg == vpfc_pkg::SEL_FB_AUTO)[*2]
      |-> !fallback_active && !active_loop_state)
      else $error("auto recovery failed");
   a_manual_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (fallback_active && sel_reg == vpfc_pkg::SEL_FB_MANUAL)
      |=> fallback_active)
      else $error("manual recovery released early");
   a_pressure_only: assert property (@(posedge sys_clk) disable iff (rst)
      (sel_reg == vpfc_pkg::SEL_PRESSURE) |=> active_loop_state)
      else $error("pressure selection not in pressure control");
   a_travel_hi_cut: assert property (@(posedge sys_clk) disable iff (rst)
      (travel_hi_reg != vpfc_pkg::CUT_OFF_HI && setpoint > travel_hi_reg)
      |=> travel_target_reg == vpfc_pkg::CUT_FORCE_HI)
      else $error("travel high cutoff not forced");
   a_travel_lo_cut: assert property (@(posedge sys_clk) disable iff (rst)
      (travel_lo_reg != vpfc_pkg::CUT_OFF_LO && setpoint < travel_lo_reg
      && !(travel_hi_reg != vpfc_pkg::CUT_OFF_HI && setpoint > travel_hi_reg))
      |=> travel_target_reg == vpfc_pkg::CUT_FORCE_LO)
      else $error("travel low cutoff not forced");
   a_press_open_cut: assert property (@(posedge sys_clk) disable iff (rst)
      (press_open_reg != vpfc_pkg::CUT_OFF_HI && setpoint > press_open_reg)
      |=> pressure_target_reg == vpfc_pkg::CUT_FORCE_HI)
      else $error("pressure open cutoff not forced");
   a_press_closed_cut: assert property (@(posedge sys_clk) disable iff (rst)
      (press_closed_reg != vpfc_pkg::CUT_OFF_LO
      && setpoint < press_closed_reg && setpoint <= press_open_reg)
      |=> pressure_target_reg == vpfc_pkg::CUT_FORCE_LO)
      else $error("pressure closed cutoff not forced");
endmodule

// ==== core/vpfc_pkg.sv ====
// Shared constants and types for the valve pressure fallback controller
package vpfc_pkg;
   // Values are signed 16-bit in tenths of a percent; gains in tenths
   typedef logic signed [15:0] vpfc_val_t;

   typedef struct packed {
      logic [15:0] prop;
      logic [15:0] integ;
      logic [15:0] minor_loop;
   } vpfc_gains_s;

   typedef enum logic [1:0] {
      SEL_TRAVEL,
      SEL_PRESSURE,
      SEL_FB_AUTO,
      SEL_FB_MANUAL
   } vpfc_sel_e;

   typedef enum logic [1:0] {
      LOOP_TRAVEL,
      LOOP_PRESSURE,
      LOOP_FALLBACK
   } vpfc_loop_e;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PROP = 8'h04;
   localparam logic [7:0] OFS_INTEG = 8'h08;
   localparam logic [7:0] OFS_MINOR_LOOP = 8'h0C;
   localparam logic [7:0] OFS_DEAD_ZONE = 8'h10;
   localparam logic [7:0] OFS_UPPER_CLAMP = 8'h14;
   localparam logic [7:0] OFS_LOWER_CLAMP = 8'h18;
   localparam logic [7:0] OFS_TRAVEL_HI = 8'h1C;
   localparam logic [7:0] OFS_TRAVEL_LO = 8'h20;
   localparam logic [7:0] OFS_PRESS_OPEN = 8'h24;
   localparam logic [7:0] OFS_PRESS_CLOSED = 8'h28;
   localparam logic [7:0] OFS_RANGE_TOP = 8'h2C;
   localparam logic [7:0] OFS_RANGE_BOTTOM = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;

   // Control and status field positions
   localparam int CTRL_PRESET_LSB = 0;
   localparam int CTRL_SEL_LSB = 4;
   localparam int STATUS_PRESSURE_BIT = 0;
   localparam int STATUS_FALLBACK_BIT = 1;

   // Preset codes: B..M fixed, then expert
   localparam logic [3:0] PRESET_B = 4'h0;
   localparam logic [3:0] PRESET_C = 4'h1;
   localparam logic [3:0] PRESET_M = 4'hB;
   localparam logic [3:0] PRESET_EXPERT = 4'hC;

   // Cutoff forcing and disable points, limits
   localparam vpfc_val_t CUT_FORCE_HI = 16'sh04CE;
   localparam vpfc_val_t CUT_FORCE_LO = 16'shFF1A;
   localparam vpfc_val_t CUT_OFF_HI = 16'sh04E2;
   localparam vpfc_val_t CUT_OFF_LO = 16'shFF06;
   localparam vpfc_val_t DEAD_ZONE_MAX = 16'sh0014;
   localparam vpfc_val_t CLAMP_MAX = 16'sh03E8;
   localparam vpfc_val_t CLAMP_MIN = 16'shFC18;
   localparam vpfc_val_t VAL_ZERO = 16'sh0000;

   // Reset values
   localparam vpfc_gains_s RST_GAINS = '{16'h0016, 16'h0001, 16'h0023};
   localparam vpfc_val_t RST_RANGE_TOP = 16'sh03E8;
   localparam vpfc_val_t RST_RANGE_BOTTOM = 16'sh0000;
endpackage

// ==== core/vpfc_gain_rom.sv ====
// Fixed pressure gain preset table with registered read data
`timescale 1ns/100ps
module vpfc_gain_rom (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Lookup
   input wire logic [3:0] addr,
   output vpfc_pkg::vpfc_gains_s q
);
   vpfc_pkg::vpfc_gains_s entry;

   always_comb begin
      unique case (addr)
         4'h0: entry = '{16'h0005, 16'h0003, 16'h0023};
         4'h1: entry = '{16'h0016, 16'h0001, 16'h0023};
         4'h2: entry = '{16'h0018, 16'h0001, 16'h0023};
         4'h3: entry = '{16'h001C, 16'h0001, 16'h0023};
         4'h4: entry = '{16'h001F, 16'h0001, 16'h0023};
         4'h5: entry = '{16'h0024, 16'h0001, 16'h0022};
         4'h6: entry = '{16'h002A, 16'h0001, 16'h001F};
         4'h7: entry = '{16'h0030, 16'h0001, 16'h001B};
         4'h8: entry = '{16'h0038, 16'h0001, 16'h0017};
         4'h9: entry = '{16'h0042, 16'h0001, 16'h0012};
         4'hA: entry = '{16'h004E, 16'h0001, 16'h000C};
         4'hB: entry = '{16'h005A, 16'h0001, 16'h000C};
         default: entry = '{16'h0000, 16'h0000, 16'h0000};
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '{16'h0000, 16'h0000, 16'h0000};
      end else begin
         q <= entry;
      end
   end
endmodule

// ==== testbench/vpfc_host.sv ====
// Fieldbus host model acting as APB master on the register port
`timescale 1ns/100ps
module vpfc_host (
   // Clock
   input wire logic sys_clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Entered just after a rising edge; one idle cycle follows each transfer
   task automatic xfer(input logic [7:0] a, input logic w,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(a, 1'b1, d, q, e);
   endtask
   // Recommended cutoffs, ordered pressure range, travel-only selection
   task automatic cfg();
      wr(vpfc_pkg::OFS_PRESS_OPEN, 32'h3E3);
      wr(vpfc_pkg::OFS_PRESS_CLOSED, 32'h5);
      wr(vpfc_pkg::OFS_TRAVEL_LO, 32'h5);
      wr(vpfc_pkg::OFS_RANGE_TOP, 32'h384);
      wr(vpfc_pkg::OFS_RANGE_BOTTOM, 32'h64);
      wr(vpfc_pkg::OFS_CTRL, 32'h1);
   endtask
endmodule

// ==== testbench/valve_pressure_fallback_ctrl_tb_top.sv ====
// Self-checking bench for the pressure tuning and loop selection block
`timescale 1ns/100ps
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
$display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module valve_pressure_fallback_ctrl_tb_top;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic signed [15:0] setpoint, pressure_error, integrator_raw;
   logic signed [15:0] travel_target, pressure_target, integrator_clamped;
   logic travel_range_fault, gross_deviation, integral_hold;
   logic active_loop_state, fallback_active;
   vpfc_pkg::vpfc_gains_s active_gains;
   int n_errors, num_checks, cycles;
   localparam logic [15:0] PG [12] = '{16'h5, 16'h16, 16'h18, 16'h1C,
      16'h1F, 16'h24, 16'h2A, 16'h30, 16'h38, 16'h42, 16'h4E, 16'h5A};
   localparam logic [15:0] ML [12] = '{16'h23, 16'h23, 16'h23, 16'h23,
      16'h23, 16'h22, 16'h1F, 16'h1B, 16'h17, 16'h12, 16'h0C, 16'h0C};

   vpfc_host u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   vpfc_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .setpoint(setpoint), .pressure_error(pressure_error),
      .integrator_raw(integrator_raw),
      .travel_range_fault(travel_range_fault),
      .gross_deviation(gross_deviation), .active_gains(active_gains),
      .travel_target(travel_target), .pressure_target(pressure_target),
      .integral_hold(integral_hold),
      .integrator_clamped(integrator_clamped),
      .active_loop_state(active_loop_state),
      .fallback_active(fallback_active));

   always #2.5 sys_clk = ~sys_clk;

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
         input logic xe);
      logic [31:0] q;
      logic e;
      u_host.xfer(a, 1'b0, 32'h0, q, e);
      `CHK(q, x)
      `CHK(e, xe)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.wr(a, d);
   endtask

   task automatic t_reset();
      `CHK(active_gains, 48'h0016_0001_0023)
      rdc(vpfc_pkg::OFS_CTRL, 32'h1, 1'b0);
      rdc(vpfc_pkg::OFS_UPPER_CLAMP, 32'h3E8, 1'b0);
      rdc(vpfc_pkg::OFS_LOWER_CLAMP, 32'hFC18, 1'b0);
      rdc(vpfc_pkg::OFS_TRAVEL_HI, 32'h4E2, 1'b0);
      rdc(vpfc_pkg::OFS_STATUS, 32'h0, 1'b0);
      rdc(8'h38, 32'h0, 1'b1);
      rdc(8'h02, 32'h0, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_presets();
      for (int i = 0; i < 12; i++) begin
         wr(vpfc_pkg::OFS_CTRL, i);
         cyc(3);
         `CHK(active_gains, {PG[i], i == 0 ? 16'h3 : 16'h1, ML[i]})
         rdc(vpfc_pkg::OFS_CTRL, i, 1'b0);
      end
      wr(vpfc_pkg::OFS_CTRL, 32'hD);
      rdc(vpfc_pkg::OFS_CTRL, 32'hB, 1'b0);
      $display("test presets done");
   endtask

   task automatic t_expert();
      wr(vpfc_pkg::OFS_PROP, 32'h64);
      rdc(vpfc_pkg::OFS_CTRL, 32'hC, 1'b0);
      wr(vpfc_pkg::OFS_INTEG, 32'h7);
      wr(vpfc_pkg::OFS_MINOR_LOOP, 32'h9);
      cyc(2);
      `CHK(active_gains, 48'h0064_0007_0009)
      wr(vpfc_pkg::OFS_CTRL, 32'h0);
      cyc(3);
      `CHK(active_gains, 48'h0005_0003_0023)
      wr(vpfc_pkg::OFS_INTEG, 32'h2);
      rdc(vpfc_pkg::OFS_CTRL, 32'hC, 1'b0);
      $display("test expert done");
   endtask

   task automatic t_integ();
      wr(vpfc_pkg::OFS_DEAD_ZONE, 32'h1E);
      rdc(vpfc_pkg::OFS_DEAD_ZONE, 32'h14, 1'b0);
      pressure_error <= 16'sh0014;
      cyc(3);
      `CHK(integral_hold, 1'b1)
      pressure_error <= 16'sh0015;
      cyc(3);
      `CHK(integral_hold, 1'b0)
      pressure_error <= 16'shFFEC;
      cyc(3);
      `CHK(integral_hold, 1'b1)
      wr(vpfc_pkg::OFS_UPPER_CLAMP, 32'h7D0);
      rdc(vpfc_pkg::OFS_UPPER_CLAMP, 32'h3E8, 1'b0);
      wr(vpfc_pkg::OFS_UPPER_CLAMP, 32'h1F4);
      wr(vpfc_pkg::OFS_LOWER_CLAMP, 32'hFED4);
      integrator_raw <= 16'sh02BC;
      cyc(3);
      `CHK(integrator_clamped, 16'sh01F4)
      integrator_raw <= 16'shFE70;
      cyc(3);
      `CHK(integrator_clamped, 16'shFED4)
      integrator_raw <= 16'sh0064;
      cyc(3);
      `CHK(integrator_clamped, 16'sh0064)
      $display("test integrator done");
   endtask

   task automatic t_cutoff();
      u_host.cfg();
      setpoint <= 16'sh01F4;
      cyc(3);
      `CHK({travel_target, pressure_target}, 32'h01F4_01F4)
      setpoint <= 16'sh0004;
      cyc(3);
      `CHK({travel_target, pressure_target}, 32'hFF1A_FF1A)
      setpoint <= 16'sh03E3;
      cyc(3);
      `CHK(pressure_target, 16'sh03E3)
      setpoint <= 16'sh03E4;
      cyc(3);
      `CHK({travel_target, pressure_target}, 32'h03E4_04CE)
      wr(vpfc_pkg::OFS_TRAVEL_HI, 32'h3E3);
      cyc(2);
      `CHK(travel_target, 16'sh04CE)
      wr(vpfc_pkg::OFS_TRAVEL_LO, 32'hFF06);
      wr(vpfc_pkg::OFS_PRESS_CLOSED, 32'hFF06);
      setpoint <= 16'shFF10;
      cyc(3);
      `CHK({travel_target, pressure_target}, 32'hFF10_FF10)
      rdc(vpfc_pkg::OFS_RANGE_TOP, 32'h384, 1'b0);
      $display("test cutoff done");
   endtask

   task automatic t_loop();
      travel_range_fault <= 1'b1;
      cyc(3);
      `CHK(active_loop_state, 1'b0)
      wr(vpfc_pkg::OFS_CTRL, 32'h11);
      rdc(vpfc_pkg::OFS_STATUS, 32'h1, 1'b0);
      wr(vpfc_pkg::OFS_CTRL, 32'h21);
      cyc(2);
      `CHK({active_loop_state, fallback_active}, 2'b11)
      travel_range_fault <= 1'b0;
      cyc(3);
      `CHK(active_loop_state, 1'b0)
      for (int k = 0; k < 2; k++) begin
         wr(vpfc_pkg::OFS_CTRL, 32'h31);
         gross_deviation <= 1'b1;
         cyc(3);
         gross_deviation <= 1'b0;
         cyc(5);
         `CHK({active_loop_state, fallback_active}, 2'b11)
         wr(vpfc_pkg::OFS_STATUS, 32'h0);
         rdc(vpfc_pkg::OFS_STATUS, 32'h3, 1'b0);
         wr(vpfc_pkg::OFS_CTRL, k == 0 ? 32'h01 : 32'h21);
         cyc(2);
         `CHK(active_loop_state, 1'b0)
      end
      $display("test loop done");
   endtask

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      setpoint = 16'sh0;
      pressure_error = 16'sh0;
      integrator_raw = 16'sh0;
      travel_range_fault = 1'b0;
      gross_deviation = 1'b0;
      cyc(12);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      t_presets();
      t_expert();
      t_integ();
      t_cutoff();
      t_loop();
      conclude();
   end
endmodule
